// [verilog/byte_port_pkg.sv]
// package for the bidirectional byte port with four handshake lines
// assumes a single 10 MHz system clock and an active-low async reset
`default_nettype none
package byte_port_pkg;

  // register indices on the register select port
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_PORT_A_CONTROL = 3'h1;
  localparam logic [2:0] REG_PORT_B_CONTROL = 3'h2;
  localparam logic [2:0] REG_GENERAL_CONTROL = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  // control register fields (same layout in port a and port b control)
  localparam int CTL_PROTO_BIT = 3;
  localparam int CTL_PIN_IRQ_EN_BIT = 2;
  localparam int CTL_SVC_EN_BIT = 1;
  localparam int CTL_STATUS_CTL_BIT = 0;

  // general control fields
  localparam int GEN_OUT_HS_EN_BIT = 4;
  localparam int GEN_IN_HS_EN_BIT = 5;
  localparam int GEN_DMA_DIR_BIT = 0;

  // status register fields
  localparam int STAT_OUT_LATCH_BIT = 0;
  localparam int STAT_OUT_READY_BIT = 1;
  localparam int STAT_IN_DATA_BIT = 2;
  localparam int STAT_IN_READY_BIT = 3;

  // values after reset
  localparam logic [7:0] PORT_A_CONTROL_RST = 8'h00;
  localparam logic [7:0] PORT_B_CONTROL_RST = 8'h00;
  localparam logic [7:0] GENERAL_CONTROL_RST = 8'h00;

  // pulsed handshake length in clock cycles
  localparam logic [2:0] HS_PULSE_CYC = 3'h4;

  // depth of each double-buffered direction
  localparam int LATCH_DEPTH = 2;

endpackage

`default_nettype wire

// [verilog/bidir_byte_port_handshake.sv]
// bidirectional double-buffered byte port with output and input handshakes
// assumes the peripheral's pins are asynchronous and the host reaches the
// registers through a simple select / strobe port on the same clock
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// small first-in first-out buffer in flip-flops
module latch_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // wrap a pointer at the last slot, depth need not be a power of two
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  // handshakes on both sides; a full buffer refuses, an empty one stalls
  assign o_in_ready = (count_r != FULL);
  assign o_out_valid = (count_r != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  assign o_out_data = mem_r[rd_ptr_r];
  assign o_count = count_r;

  // storage written only on an accepted push, oldest entry read first
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop)
      begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop)
      begin
        count_r <= CW'(count_r + 1'b1);
      end
      else if (pop && !push)
      begin
        count_r <= CW'(count_r - 1'b1);
      end
    end
  end
endmodule // latch_fifo

////////////////////////////////////////////////////////////////////////////////
// the port itself
module bidir_byte_port_handshake
#(
  parameter int DEPTH = byte_port_pkg::LATCH_DEPTH
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host register port
  input wire logic i_reg_sel,
  input wire logic i_reg_write,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_write_ready,
  // peripheral side
  input wire logic [7:0] i_port_pins,
  output logic [7:0] o_port_pins,
  output logic o_port_pins_oe,
  input wire logic i_out_ack_strobe,
  output logic o_out_ready_handshake,
  input wire logic i_in_data_strobe,
  output logic o_in_ready_handshake,
  // requests
  output logic o_dma_request_pin,
  output logic o_service_request
);
  import byte_port_pkg::*;

  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [7:0] port_a_control_r;
  logic [7:0] port_b_control_r;
  logic [7:0] general_control_r;
  logic [7:0] reg_rdata_r;
  logic reg_write_ready_r;
  logic [7:0] pins_s1_r;
  logic [7:0] pins_s2_r;
  logic [2:0] ack_sync_r;
  logic [2:0] stb_sync_r;
  logic ack_edge;
  logic stb_edge;
  logic out_hs_en;
  logic in_hs_en;
  logic out_pulsed;
  logic in_pulsed;
  logic out_win_r;
  logic out_win_nxt;
  logic in_win_r;
  logic in_win_nxt;
  logic [2:0] out_cnt_r;
  logic [2:0] in_cnt_r;
  logic out_hs_r;
  logic in_hs_r;
  logic [7:0] port_out_r;
  logic port_oe_r;
  logic dma_r;
  logic svc_r;
  logic in_push;
  logic in_pop;
  logic in_ready;
  logic in_valid;
  logic [7:0] in_head;
  logic [CW-1:0] in_count;
  logic out_push;
  logic out_pop;
  logic out_ready;
  logic out_valid;
  logic [7:0] out_head;
  logic [CW-1:0] out_count;
  logic host_read;
  logic host_write;
  logic out_latch_status;
  logic in_data_status;
  logic out_ready_status;
  logic in_ready_status;
  logic [7:0] status_word;

  //////////////////////////////////////////////////////////////////////////////
  // helpers shared by both handshake directions

  // window opens once a transfer is possible, closes on an accepted edge
  function automatic logic win_next(input logic en, input logic win,
                                    input logic edge_seen, input logic cond);
    if (!en)
    begin
      win_next = 1'b0;
    end
    else if (win)
    begin
      win_next = !edge_seen;
    end
    else
    begin
      win_next = cond;
    end
  endfunction

  // handshake pin level: a pulse stops after the set count of cycles
  function automatic logic hs_level(input logic win_upd, input logic win,
                                    input logic pulsed,
                                    input logic [2:0] cnt);
    hs_level = win_upd && (!pulsed || !win || (cnt < HS_PULSE_CYC));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds only stage two
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pins_s1_r <= 8'h00;
      pins_s2_r <= 8'h00;
      ack_sync_r <= 3'h7; // idles high: no false edge, drivers stay off
      stb_sync_r <= 3'h0;
    end
    else
    begin
      pins_s1_r <= i_port_pins;
      pins_s2_r <= pins_s1_r;
      ack_sync_r <= {ack_sync_r[1:0], i_out_ack_strobe};
      stb_sync_r <= {stb_sync_r[1:0], i_in_data_strobe};
    end
  end

  // rising edges seen after the second stage
  assign ack_edge = ack_sync_r[1] && !ack_sync_r[2];
  assign stb_edge = stb_sync_r[1] && !stb_sync_r[2];

  //////////////////////////////////////////////////////////////////////////////
  // control decode
  assign out_hs_en = general_control_r[GEN_OUT_HS_EN_BIT];
  assign in_hs_en = general_control_r[GEN_IN_HS_EN_BIT];
  assign out_pulsed = port_a_control_r[CTL_PROTO_BIT];
  assign in_pulsed = port_b_control_r[CTL_PROTO_BIT];

  // host access strobes
  assign host_read = i_reg_sel && !i_reg_write;
  assign host_write = i_reg_sel && i_reg_write;

  //////////////////////////////////////////////////////////////////////////////
  // input path: strobe edges only count while the window is open
  assign in_push = stb_edge && in_win_r;
  assign in_pop = host_read && (i_reg_addr == REG_DATA);

  latch_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) in_latches (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(in_push),
    .o_in_ready(in_ready),
    .i_in_data(pins_s2_r),
    .o_out_valid(in_valid),
    .i_out_ready(in_pop),
    .o_out_data(in_head),
    .o_count(in_count)
  );

  // output path: host writes queue, accepted acknowledge drains
  assign out_push = host_write && (i_reg_addr == REG_DATA);
  assign out_pop = ack_edge && out_win_r;

  latch_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) out_latches (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(out_push),
    .o_in_ready(out_ready),
    .i_in_data(i_reg_wdata),
    .o_out_valid(out_valid),
    .i_out_ready(out_pop),
    .o_out_data(out_head),
    .o_count(out_count)
  );

  //////////////////////////////////////////////////////////////////////////////
  // handshake windows; the fifo level already reflects last cycle's move
  assign in_win_nxt = win_next(in_hs_en, in_win_r, stb_edge,
                               in_ready);
  assign out_win_nxt = win_next(out_hs_en, out_win_r, ack_edge,
                                out_valid);

  // window state, one per direction
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_win_r <= 1'b0;
      out_win_r <= 1'b0;
    end
    else
    begin
      in_win_r <= in_win_nxt;
      out_win_r <= out_win_nxt;
    end
  end

  // pulse length counters restart as each window opens
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_cnt_r <= 3'h0;
      out_cnt_r <= 3'h0;
    end
    else
    begin
      if (!in_win_r && in_win_nxt)
      begin
        in_cnt_r <= 3'h1;
      end
      else if (in_win_r && (in_cnt_r < HS_PULSE_CYC))
      begin
        in_cnt_r <= 3'(in_cnt_r + 1'b1);
      end
      if (!out_win_r && out_win_nxt)
      begin
        out_cnt_r <= 3'h1;
      end
      else if (out_win_r && (out_cnt_r < HS_PULSE_CYC))
      begin
        out_cnt_r <= 3'(out_cnt_r + 1'b1);
      end
    end
  end

  // handshake pins; a pulse keeps the window open so a late edge still
  // transfers, but the pin itself falls after four cycles
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_hs_r <= 1'b0;
      out_hs_r <= 1'b0;
    end
    else
    begin
      in_hs_r <= hs_level(in_win_nxt, in_win_r, in_pulsed,
                          in_cnt_r);
      out_hs_r <= hs_level(out_win_nxt, out_win_r, out_pulsed,
                           out_cnt_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port drivers follow the acknowledge level; data is the oldest byte
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      port_out_r <= 8'h00;
      port_oe_r <= 1'b0;
    end
    else
    begin
      if (out_valid)
      begin
        port_out_r <= out_head;
      end
      port_oe_r <= !ack_sync_r[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags
  assign out_latch_status = port_a_control_r[CTL_STATUS_CTL_BIT] ?
                            (out_count == '0) :
                            (out_count != FULL);
  assign in_data_status = in_valid;
  assign out_ready_status = 1'b0;
  assign in_ready_status = 1'b0;

  // status word read by the host
  always_comb
  begin
    status_word = 8'h00;
    status_word[STAT_OUT_LATCH_BIT] = out_latch_status;
    status_word[STAT_OUT_READY_BIT] = out_ready_status;
    status_word[STAT_IN_DATA_BIT] = in_data_status;
    status_word[STAT_IN_READY_BIT] = in_ready_status;
  end

  //////////////////////////////////////////////////////////////////////////////
  // requests; the pin-event sources stay zero here but keep their gates
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      svc_r <= 1'b0;
      dma_r <= 1'b0;
    end
    else
    begin
      svc_r <= (port_a_control_r[CTL_PIN_IRQ_EN_BIT]
                && out_ready_status)
            || (port_a_control_r[CTL_SVC_EN_BIT]
                && out_latch_status)
            || (port_b_control_r[CTL_PIN_IRQ_EN_BIT]
                && in_ready_status)
            || (port_b_control_r[CTL_SVC_EN_BIT]
                && in_data_status);
      // one direction only, picked by the dma direction bit
      if (general_control_r[GEN_DMA_DIR_BIT])
      begin
        dma_r <= port_b_control_r[CTL_SVC_EN_BIT]
                 && in_data_status;
      end
      else
      begin
        dma_r <= port_a_control_r[CTL_SVC_EN_BIT]
                 && out_latch_status;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers written by the host
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      port_a_control_r <= PORT_A_CONTROL_RST;
      port_b_control_r <= PORT_B_CONTROL_RST;
      general_control_r <= GENERAL_CONTROL_RST;
    end
    else if (host_write)
    begin
      if (i_reg_addr == REG_PORT_A_CONTROL)
      begin
        port_a_control_r <= i_reg_wdata;
      end
      else if (i_reg_addr == REG_PORT_B_CONTROL)
      begin
        port_b_control_r <= i_reg_wdata;
      end
      else if (i_reg_addr == REG_GENERAL_CONTROL)
      begin
        general_control_r <= i_reg_wdata;
      end
    end
  end

  // read data one cycle after the select; unmapped indices read zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      reg_rdata_r <= 8'h00;
    end
    else if (host_read)
    begin
      if (i_reg_addr == REG_DATA)
      begin
        reg_rdata_r <= in_valid ? in_head : 8'h00;
      end
      else if (i_reg_addr == REG_PORT_A_CONTROL)
      begin
        reg_rdata_r <= port_a_control_r;
      end
      else if (i_reg_addr == REG_PORT_B_CONTROL)
      begin
        reg_rdata_r <= port_b_control_r;
      end
      else if (i_reg_addr == REG_GENERAL_CONTROL)
      begin
        reg_rdata_r <= general_control_r;
      end
      else if (i_reg_addr == REG_STATUS)
      begin
        reg_rdata_r <= status_word;
      end
      else
      begin
        reg_rdata_r <= 8'h00;
      end
    end
  end

  // write-ready lags the buffer by a cycle; a write into a full buffer
  // is simply dropped, so software should check the latch flag first
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      reg_write_ready_r <= 1'b0;
    end
    else
    begin
      reg_write_ready_r <= out_ready && !out_push;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign o_reg_rdata = reg_rdata_r;
  assign o_reg_write_ready = reg_write_ready_r;
  assign o_port_pins = port_out_r;
  assign o_port_pins_oe = port_oe_r;
  assign o_out_ready_handshake = out_hs_r;
  assign o_in_ready_handshake = in_hs_r;
  assign o_dma_request_pin = dma_r;
  assign o_service_request = svc_r;

endmodule // bidir_byte_port_handshake

`default_nettype wire

// [tb/bidir_byte_port_asserts.sv]
// checker for the byte port, sees only the top module's ports
// assumes one clock domain and the active-low async reset
`timescale 1ns/1ps
`default_nettype none
module byte_port_asserts
  import byte_port_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_sel,
  input wire logic i_reg_write,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_write_ready,
  input wire logic [7:0] i_port_pins,
  input wire logic [7:0] o_port_pins,
  input wire logic o_port_pins_oe,
  input wire logic i_out_ack_strobe,
  input wire logic o_out_ready_handshake,
  input wire logic i_in_data_strobe,
  input wire logic o_in_ready_handshake,
  input wire logic o_dma_request_pin,
  input wire logic o_service_request
);
  logic [7:0] pa_r;
  logic [7:0] pb_r;
  logic [7:0] gen_r;
  logic wr;
  logic rd_stat;
  assign wr = i_reg_sel && i_reg_write;
  assign rd_stat = i_reg_sel && !i_reg_write && i_reg_addr == REG_STATUS;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the control registers, rebuilt from host writes
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pa_r <= PORT_A_CONTROL_RST;
      pb_r <= PORT_B_CONTROL_RST;
      gen_r <= GENERAL_CONTROL_RST;
    end
    else if (wr)
    begin
      if (i_reg_addr == REG_PORT_A_CONTROL) pa_r <= i_reg_wdata;
      if (i_reg_addr == REG_PORT_B_CONTROL) pb_r <= i_reg_wdata;
      if (i_reg_addr == REG_GENERAL_CONTROL) gen_r <= i_reg_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  in_off_a: assert property (
    (!gen_r[GEN_IN_HS_EN_BIT]) [*2] |-> !o_in_ready_handshake)
    else $error("input ready while disabled");
  out_off_a: assert property (
    (!gen_r[GEN_OUT_HS_EN_BIT]) [*2] |-> !o_out_ready_handshake)
    else $error("output ready while disabled");
  in_pulse_a: assert property (
    pb_r[CTL_PROTO_BIT] && $rose(o_in_ready_handshake)
    |-> ##[1:4] !o_in_ready_handshake)
    else $error("input ready pulse too long");
  out_pulse_a: assert property (
    pa_r[CTL_PROTO_BIT] && $rose(o_out_ready_handshake)
    |-> ##[1:4] !o_out_ready_handshake)
    else $error("output ready pulse too long");
  oe_off_a: assert property (
    i_out_ack_strobe [*4] |-> !o_port_pins_oe)
    else $error("drivers on while acknowledge high");
  oe_on_a: assert property (
    !i_out_ack_strobe [*4] |-> o_port_pins_oe)
    else $error("drivers off while acknowledge low");
  dma_gate_a: assert property (
    (gen_r[GEN_DMA_DIR_BIT] ? !pb_r[CTL_SVC_EN_BIT] : !pa_r[CTL_SVC_EN_BIT])
    [*2] |-> !o_dma_request_pin)
    else $error("dma request from gated direction");
  svc_gate_a: assert property (
    (!pa_r[CTL_SVC_EN_BIT] && !pb_r[CTL_SVC_EN_BIT]) [*2]
    |-> !o_service_request)
    else $error("service request while disabled");
  stat_zero_a: assert property (
    rd_stat |=> !o_reg_rdata[STAT_OUT_READY_BIT]
    && !o_reg_rdata[STAT_IN_READY_BIT])
    else $error("ready status bits not zero");
  out_rise_a: assert property (
    wr && i_reg_addr == REG_DATA && gen_r[GEN_OUT_HS_EN_BIT]
    && !pa_r[CTL_PROTO_BIT] |-> ##[1:8] o_out_ready_handshake)
    else $error("output ready missing after write");
  cover property ($fell(o_in_ready_handshake));
  cover property (pa_r[CTL_PROTO_BIT] && $rose(o_out_ready_handshake));
  cover property (o_dma_request_pin && gen_r[GEN_DMA_DIR_BIT]);
endmodule
// byte_port_asserts

bind bidir_byte_port_handshake byte_port_asserts #(.DEPTH(DEPTH)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_sel(i_reg_sel),
  .i_reg_write(i_reg_write), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_write_ready(o_reg_write_ready), .i_port_pins(i_port_pins),
  .o_port_pins(o_port_pins), .o_port_pins_oe(o_port_pins_oe),
  .i_out_ack_strobe(i_out_ack_strobe),
  .o_out_ready_handshake(o_out_ready_handshake),
  .i_in_data_strobe(i_in_data_strobe),
  .o_in_ready_handshake(o_in_ready_handshake),
  .o_dma_request_pin(o_dma_request_pin),
  .o_service_request(o_service_request));
`default_nettype wire

// [tb/periph_model.sv]
// peripheral on the far side: takes and sends bytes by handshake
// assumes the bench resolves the shared pins from the drivers' enable
`timescale 1ns/1ps
`default_nettype none
module periph_model
(
  input wire logic i_clk,
  input wire logic i_out_rdy,
  input wire logic i_in_rdy,
  input wire logic [7:0] i_pins,
  output logic o_ack,
  output logic o_stb,
  output logic [7:0] o_pins
);
  // ack idles high so the pins stay inputs of the device
  initial
  begin
    o_ack = 1'b1;
    o_stb = 1'b0;
    o_pins = 8'h00;
  end
  // accept one byte; ack falls once output ready is up or the 60-cycle wait runs out
  task automatic take(output logic [7:0] d, output bit ok);
    int n = 0;
    @(negedge i_clk);
    while (i_out_rdy !== 1'b1 && n < 60)
    begin
      @(negedge i_clk);
      n++;
    end
    ok = (n < 60);
    o_ack = 1'b0;
    repeat (6) @(negedge i_clk);
    d = i_pins;
    o_ack = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
  // offer one byte; chk low strobes without waiting, to be ignored
  task automatic send(input logic [7:0] d, input bit chk, output bit ok);
    int n = 0;
    @(negedge i_clk);
    while (chk && i_in_rdy !== 1'b1 && n < 60)
    begin
      @(negedge i_clk);
      n++;
    end
    ok = (n < 60);
    o_pins = d;
    repeat (3) @(negedge i_clk);
    o_stb = 1'b1;
    repeat (4) @(negedge i_clk);
    o_stb = 1'b0;
    repeat (2) @(negedge i_clk);
    o_pins = ~d; // released: no stale value
    repeat (4) @(negedge i_clk);
  endtask
endmodule
// periph_model
`default_nettype wire

// [tb/bidir_byte_port_handshake_tb.sv]
// self-checking bench for the byte port with a peripheral model
// assumes the design package and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module bidir_byte_port_handshake_tb;
  import byte_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic we = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wready;
  logic [7:0] pins_drv;
  logic pins_oe;
  logic [7:0] p_pins;
  logic [7:0] pin_bus;
  logic ack;
  logic stb;
  logic out_rdy;
  logic in_rdy;
  logic dma;
  logic svc;
  int fail_count = 0;
  int n_checks = 0;
  logic [7:0] d;
  bit ok;
  always #50 clk = ~clk;
  // shared pins: device drives only while its enable is up
  assign pin_bus = pins_oe ? pins_drv : p_pins;
  bidir_byte_port_handshake uut (.i_clk(clk), .i_rst_n(rst_n),
    .i_reg_sel(sel), .i_reg_write(we), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_write_ready(wready),
    .i_port_pins(pin_bus), .o_port_pins(pins_drv),
    .o_port_pins_oe(pins_oe), .i_out_ack_strobe(ack),
    .o_out_ready_handshake(out_rdy), .i_in_data_strobe(stb),
    .o_in_ready_handshake(in_rdy), .o_dma_request_pin(dma),
    .o_service_request(svc));
  periph_model p (.i_clk(clk), .i_out_rdy(out_rdy), .i_in_rdy(in_rdy),
    .i_pins(pin_bus), .o_ack(ack), .o_stb(stb), .o_pins(p_pins));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // a wait that ran out ends the run
  task automatic need(input bit good);
    if (!good)
    begin
      fail_count++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    sel = 1'b1;
    we = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    sel = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(negedge clk);
    sel = 1'b1;
    we = 1'b0;
    addr = a;
    @(negedge clk);
    sel = 1'b0;
    v = rdata;
  endtask
  task automatic stat(input logic [7:0] exp);
    logic [7:0] v;
    rd(REG_STATUS, v);
    check("status", exp, v & 8'h0f);
  endtask
  // counts the cycles of one ready pulse, o selects the output side
  task automatic pulse(input bit o, output logic [7:0] len);
    int n = 0;
    len = 8'h00;
    while ((o ? out_rdy : in_rdy) !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    need(n < 40);
    while ((o ? out_rdy : in_rdy) === 1'b1 && len < 8'h10)
    begin
      @(negedge clk);
      len++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] v;
    rd(REG_PORT_A_CONTROL, v);
    check("port_a_control", PORT_A_CONTROL_RST, v);
    rd(REG_PORT_B_CONTROL, v);
    check("port_b_control", PORT_B_CONTROL_RST, v);
    wr(REG_PORT_A_CONTROL, 8'h06);
    rd(REG_PORT_A_CONTROL, v);
    check("port_a_control rw", 8'h06, v);
    wr(3'h7, 8'hff);
    rd(3'h7, v);
    check("unmapped", 8'h00, v);
    wr(REG_PORT_A_CONTROL, 8'h00);
    stat(8'h01);
    check("write ready idle", 8'h01, {7'h00, wready});
    $display("register test done");
  endtask
  task automatic t_out;
    wr(REG_GENERAL_CONTROL, 8'h10);
    wr(REG_DATA, 8'ha1);
    wr(REG_DATA, 8'ha2);
    wr(REG_DATA, 8'ha3);
    check("write ready", 8'h00, {7'h00, wready});
    stat(8'h00);
    wr(REG_PORT_A_CONTROL, 8'h01);
    p.take(d, ok);
    need(ok);
    check("first byte out", 8'ha1, d);
    stat(8'h00);
    wr(REG_PORT_A_CONTROL, 8'h00);
    stat(8'h01);
    wr(REG_PORT_A_CONTROL, 8'h03);
    p.take(d, ok);
    need(ok);
    check("second byte out", 8'ha2, d);
    stat(8'h01);
    check("out ready idle", 8'h00, {7'h00, out_rdy});
    check("dma from ack side", 8'h01, {7'h00, dma});
    check("service", 8'h01, {7'h00, svc});
    $display("output test done");
  endtask
  task automatic t_in;
    logic [7:0] v;
    wr(REG_PORT_A_CONTROL, 8'h02);
    wr(REG_PORT_B_CONTROL, 8'h02);
    wr(REG_GENERAL_CONTROL, 8'h21);
    repeat (3) @(negedge clk);
    check("dma one side", 8'h00, {7'h00, dma});
    p.send(8'hb1, 1'b1, ok);
    need(ok);
    p.send(8'hb2, 1'b1, ok);
    need(ok);
    check("ready when full", 8'h00, {7'h00, in_rdy});
    p.send(8'hb3, 1'b0, ok);
    stat(8'h05);
    wr(REG_PORT_B_CONTROL, 8'h03);
    stat(8'h05);
    check("dma from strobe side", 8'h01, {7'h00, dma});
    rd(REG_DATA, v);
    check("first byte in", 8'hb1, v);
    rd(REG_DATA, v);
    check("second byte in", 8'hb2, v);
    rd(REG_DATA, v);
    check("ignored strobe", 8'h00, v);
    repeat (4) @(negedge clk);
    check("ready again", 8'h01, {7'h00, in_rdy});
    check("dma idle", 8'h00, {7'h00, dma});
    $display("input test done");
  endtask
  task automatic t_pulse;
    logic [7:0] len;
    wr(REG_GENERAL_CONTROL, 8'h00);
    repeat (3) @(negedge clk);
    check("in ready disabled", 8'h00, {7'h00, in_rdy});
    wr(REG_PORT_B_CONTROL, 8'h08);
    wr(REG_GENERAL_CONTROL, 8'h20);
    pulse(1'b0, len);
    check("in pulse", {5'h00, HS_PULSE_CYC}, len);
    wr(REG_GENERAL_CONTROL, 8'h00);
    wr(REG_PORT_A_CONTROL, 8'h08);
    wr(REG_GENERAL_CONTROL, 8'h10);
    wr(REG_DATA, 8'h5a);
    pulse(1'b1, len);
    check("out pulse", {5'h00, HS_PULSE_CYC}, len);
    $display("pulse test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    t_out;
    t_in;
    t_pulse;
    complete_run;
  end
endmodule
// bidir_byte_port_handshake_tb
`default_nettype wire
